// *** src/sadr_decoder.v ***
// System address decoder with internal remap and flash access steering.
// Operation
// - Sixteen 256-Mbyte areas select the target.
// - Areas 1 to 8 drive external selects 0-7.
// - Area 0 splits into 1-Mbyte internal regions.
// - Area 15 goes to the peripheral bus.
// - Unassigned areas answer the master with abort.
// - Before remap SRAM answers only at base.
// - After remap SRAM also answers at zero.
// - ROM always answers at its base.
// - Flash always answers at its base.
// - Boot bit set boots flash, clear boots ROM.
// - Erase clears the boot bit.
// - Boot bit changes only via set/clear commands, erase and the stored-level load after reset.
// - SRAM window sized 32 or 8 kilobytes.
// - Flash reads as contiguous words, sized per variant.
// - Two planes: read one while other programs.
// - Page write buffer through 32-bit writes.
// - Dual word prefetch serves consecutive halfword fetches.
// - Remap puts SRAM at zero for vectors.
`timescale 1ns/100ps
`include "sadr_map.vh"
module sadr_decoder
#(
   parameter SRAM_BYTES  = `SADR_SRAM_BYTES,
   parameter FLASH_WORDS = `SADR_FLASH_WORDS,
   parameter WBUF_BYTES  = `SADR_WBUF_BYTES,
   parameter DUAL_PLANE  = 1
)
(
   // Clock and reset.
   input  wire        core_clk_in,
   input  wire        reset_in,
   // Master request.
   input  wire        req_valid_in,
   input  wire [31:0] req_addr_in,
   input  wire        req_write_in,
   // Remap command pulse from the memory controller.
   input  wire        remap_cmd_in,
   // Non-volatile bit commands from the flash controller.
   input  wire        nv_set_in,
   input  wire        nv_clear_in,
   input  wire [1:0]  nv_bit_in,
   input  wire        nv_boot_stored_in,
   // Erase pin.
   input  wire        erase_pin_in,
   // Plane programming busy flags from the flash controllers.
   input  wire [1:0]  plane_busy_in,
   // Flash array fill answer for the prefetch buffer.
   input  wire        fill_valid_in,
   input  wire [63:0] fill_data_in,
   // Target selects.
   output reg         sram_sel_out,
   output reg         rom_sel_out,
   output reg         flash_sel_out,
   output reg         wbuf_sel_out,
   output reg         periph_sel_out,
   output reg  [7:0]  external_select_n_out,
   output reg         abort_out,
   output reg         stall_out,
   // Offsets toward the selected target.
   output reg  [19:0] mem_offset_out,
   output reg  [$clog2(FLASH_WORDS)-1:0]  flash_word_out,
   output reg         flash_plane_out,
   output reg  [$clog2(WBUF_BYTES/4)-1:0] wbuf_index_out,
   // Prefetch answer and flash fetch request.
   output reg         prefetch_hit_out,
   output reg  [31:0] prefetch_data_out,
   output reg         flash_fetch_out,
   // Mapping state.
   output reg         boot_flash_out,
   output reg         remapped_out
);

   // Width of a flash word index and a write buffer word index.
   localparam FW = $clog2(FLASH_WORDS);
   localparam BW = $clog2(WBUF_BYTES / 4);
   // Words per plane; the upper half belongs to the second plane.
   localparam PLANE_WORDS = DUAL_PLANE ? FLASH_WORDS / 2 : FLASH_WORDS;

   // Picks what answers at region 0 given remap and boot state.
   function [1:0] sadr_zero_target;
      input remap;
      input boot_flash;
      begin
         if (remap)
            sadr_zero_target = `SADR_TGT_SRAM;
         else if (boot_flash)
            sadr_zero_target = `SADR_TGT_FLASH;
         else
            sadr_zero_target = `SADR_TGT_ROM;
      end
   endfunction

   wire          nv_boot_w;      // Boot bit from the keeper.
   wire          nv_remap_w;     // Remap state from the keeper.
   wire          pf_hit_w;       // Prefetch lookup hit.
   wire [31:0]   pf_data_w;      // Prefetch lookup data.
   wire [3:0]    area_w;         // Area index.
   wire [7:0]    region_w;       // Internal region index.
   wire [19:0]   offset_w;       // Byte offset within a region.
   wire [FW-1:0] word_w;         // Word offset within the flash.
   wire          plane_w;        // Plane holding that word.

   reg  [1:0]    tgt_next;       // Internal target of this request.
   reg           sram_next;
   reg           rom_next;
   reg           flash_next;
   reg           wbuf_next;
   reg           periph_next;
   reg  [7:0]    ext_n_next;
   reg           abort_next;
   reg           stall_next;
   reg           fetch_next;
   reg  [FW-1:0] fetch_word_reg; // Word whose pair is being fetched.
   reg           fetch_busy_reg; // A pair fetch is outstanding.

   // Field split of the request address.
   assign area_w   = req_addr_in[`SADR_AREA_MSB:`SADR_AREA_LSB];
   assign region_w = req_addr_in[`SADR_REGION_MSB:`SADR_REGION_LSB];
   assign offset_w = req_addr_in[19:0];
   assign word_w   = offset_w[FW+1:2];
   assign plane_w  = (DUAL_PLANE != 0) && (word_w >= PLANE_WORDS);

   // Boot bit and remap state.
   sadr_nvbits u_nvbits
   (
      .core_clk_in       (core_clk_in),
      .reset_in          (reset_in),
      .nv_boot_stored_in (nv_boot_stored_in),
      .nv_set_in         (nv_set_in),
      .nv_clear_in       (nv_clear_in),
      .nv_bit_in         (nv_bit_in),
      .erase_pin_in      (erase_pin_in),
      .remap_cmd_in      (remap_cmd_in),
      .boot_flash_out    (nv_boot_w),
      .remapped_out      (nv_remap_w)
   );

   // Flash prefetch pair; flushed by any programming activity.
   sadr_prefetch #(.AW(FW)) u_prefetch
   (
      .core_clk_in   (core_clk_in),
      .reset_in      (reset_in),
      .look_word_in  (word_w),
      .fill_valid_in (fill_valid_in),
      .fill_word_in  (fetch_word_reg),
      .fill_data_in  (fill_data_in),
      .flush_in      (|plane_busy_in),
      .hit_out       (pf_hit_w),
      .data_out      (pf_data_w)
   );

   // First level decode, then second level inside area 0.
   always @*
   begin
      tgt_next    = `SADR_TGT_NONE;
      sram_next   = 1'b0;
      rom_next    = 1'b0;
      flash_next  = 1'b0;
      wbuf_next   = 1'b0;
      periph_next = 1'b0;
      ext_n_next  = 8'hff;
      abort_next  = 1'b0;
      stall_next  = 1'b0;
      fetch_next  = 1'b0;
      if (req_valid_in)
      begin
         // Region 0 follows the alias; the fixed bases never move.
         case (region_w)
            `SADR_REGION_BOOT:
               tgt_next = sadr_zero_target(nv_remap_w, nv_boot_w);
            `SADR_REGION_FLASH:
               tgt_next = `SADR_TGT_FLASH;
            `SADR_REGION_SRAM:
               tgt_next = `SADR_TGT_SRAM;
            `SADR_REGION_ROM:
               tgt_next = `SADR_TGT_ROM;
            default:
               tgt_next = `SADR_TGT_NONE;
         endcase
         if (area_w == `SADR_AREA_INTERNAL)
         begin
            case (tgt_next)
               `SADR_TGT_SRAM:
               begin
                  // Beyond the fitted SRAM size the access is refused.
                  if (offset_w < SRAM_BYTES)
                     sram_next = 1'b1;
                  else
                     abort_next = 1'b1;
               end
               `SADR_TGT_ROM:
                  rom_next = 1'b1;
               `SADR_TGT_FLASH:
               begin
                  if (offset_w >= FLASH_WORDS * 4)
                     abort_next = 1'b1;
                  else if (req_write_in)
                     wbuf_next = 1'b1;
                  else if (plane_busy_in[plane_w])
                     stall_next = 1'b1;
                  else if (pf_hit_w)
                     flash_next = 1'b1;
                  else
                  begin
                     flash_next = 1'b1;
                     fetch_next = !fetch_busy_reg;
                  end
               end
               default:
                  abort_next = 1'b1;
            endcase
         end
         else if (area_w >= `SADR_AREA_EXT_FIRST &&
                  area_w <= `SADR_AREA_EXT_LAST)
         begin
            // One select per area, area 1 on select 0.
            ext_n_next[area_w[2:0] - 3'h1] = 1'b0;
         end
         else if (area_w == `SADR_AREA_PERIPH)
            periph_next = 1'b1;
         else
            abort_next = 1'b1;
      end
   end

   // Outstanding pair fetch; ends when the array returns the pair.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         fetch_busy_reg <= 1'b0;
         fetch_word_reg <= {FW{1'b0}};
      end
      else if (fill_valid_in)
         fetch_busy_reg <= 1'b0;
      else if (fetch_next)
      begin
         fetch_busy_reg <= 1'b1;
         fetch_word_reg <= word_w;
      end
   end

   // All outputs are registered one cycle after the request.
   // The decode is purely combinational before this stage, which keeps
   // latency fixed at one cycle for every target, aborts included.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sram_sel_out          <= 1'b0;
         rom_sel_out           <= 1'b0;
         flash_sel_out         <= 1'b0;
         wbuf_sel_out          <= 1'b0;
         periph_sel_out        <= 1'b0;
         external_select_n_out <= 8'hff;
         abort_out             <= 1'b0;
         stall_out             <= 1'b0;
         mem_offset_out        <= 20'h0;
         flash_word_out        <= {FW{1'b0}};
         flash_plane_out       <= 1'b0;
         wbuf_index_out        <= {BW{1'b0}};
         prefetch_hit_out      <= 1'b0;
         prefetch_data_out     <= 32'h0;
         flash_fetch_out       <= 1'b0;
         boot_flash_out        <= 1'b0;
         remapped_out          <= 1'b0;
      end
      else
      begin
         sram_sel_out          <= sram_next;
         rom_sel_out           <= rom_next;
         flash_sel_out         <= flash_next;
         wbuf_sel_out          <= wbuf_next;
         periph_sel_out        <= periph_next;
         external_select_n_out <= ext_n_next;
         abort_out             <= abort_next;
         stall_out             <= stall_next;
         mem_offset_out        <= offset_w;
         flash_word_out        <= word_w;
         flash_plane_out       <= plane_w;
         wbuf_index_out        <= offset_w[BW+1:2];
         prefetch_hit_out      <= flash_next && pf_hit_w;
         prefetch_data_out     <= pf_data_w;
         flash_fetch_out       <= fetch_next;
         boot_flash_out        <= nv_boot_w;
         remapped_out          <= nv_remap_w;
      end
   end

endmodule // sadr_decoder

// *** inc/sadr_map.vh ***
// Address map constants for the system address decoder.
`ifndef SADR_MAP_VH
`define SADR_MAP_VH
// First level areas, index taken from address bits 31..28.
`define SADR_AREA_MSB       31
`define SADR_AREA_LSB       28
`define SADR_AREA_INTERNAL  4'h0
`define SADR_AREA_EXT_FIRST 4'h1
`define SADR_AREA_EXT_LAST  4'h8
`define SADR_AREA_PERIPH    4'hf
// Second level regions inside area 0, index from bits 27..20.
`define SADR_REGION_MSB     27
`define SADR_REGION_LSB     20
`define SADR_REGION_BOOT    8'h00
`define SADR_REGION_FLASH   8'h01
`define SADR_REGION_SRAM    8'h02
`define SADR_REGION_ROM     8'h03
// Fixed base addresses of the internal memories.
`define SADR_FLASH_BASE     32'h0010_0000
`define SADR_SRAM_BASE      32'h0020_0000
`define SADR_ROM_BASE       32'h0030_0000
// Internal target codes.
`define SADR_TGT_NONE       2'h0
`define SADR_TGT_FLASH      2'h1
`define SADR_TGT_SRAM       2'h2
`define SADR_TGT_ROM        2'h3
// Non-volatile bit number that selects the boot memory.
`define SADR_BOOT_NV_BIT    2'h2
// Sizes per variant, in bytes or words.
`define SADR_SRAM_BYTES     32768
`define SADR_FLASH_WORDS    131072
`define SADR_WBUF_BYTES     256
`endif

// *** src/sadr_nvbits.v ***
// Boot select bit and remap state keeper.
`timescale 1ns/100ps
`include "sadr_map.vh"
module sadr_nvbits
(
   // Clock and reset.
   input  wire       core_clk_in,
   input  wire       reset_in,
   // Stored boot bit level as held in the non-volatile array.
   input  wire       nv_boot_stored_in,
   // Flash controller set or clear commands with bit number.
   input  wire       nv_set_in,
   input  wire       nv_clear_in,
   input  wire [1:0] nv_bit_in,
   // Erase pin, asynchronous to the core clock.
   input  wire       erase_pin_in,
   // Remap command pulse.
   input  wire       remap_cmd_in,
   // State outputs.
   output reg        boot_flash_out,
   output reg        remapped_out
);

   reg erase_meta_reg;   // First synchroniser stage, read only below.
   reg erase_sync_reg;   // Second synchroniser stage.
   reg loaded_reg;       // High once the stored level was captured.

   // Erase pin synchroniser.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         erase_meta_reg <= 1'b0;
         erase_sync_reg <= 1'b0;
      end
      else
      begin
         erase_meta_reg <= erase_pin_in;
         erase_sync_reg <= erase_meta_reg;
      end
   end

   // The stored level is caught after reset release, never by the reset
   // itself, so the bit survives reset as a non-volatile bit must.
   // Erase beats a set command arriving in the same cycle.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         loaded_reg     <= 1'b0;
         boot_flash_out <= 1'b0;
      end
      else if (erase_sync_reg)
      begin
         loaded_reg     <= 1'b1;
         boot_flash_out <= 1'b0;
      end
      else if (!loaded_reg)
      begin
         loaded_reg     <= 1'b1;
         boot_flash_out <= nv_boot_stored_in;
      end
      else if (nv_set_in && nv_bit_in == `SADR_BOOT_NV_BIT)
      begin
         boot_flash_out <= 1'b1;
      end
      else if (nv_clear_in && nv_bit_in == `SADR_BOOT_NV_BIT)
      begin
         boot_flash_out <= 1'b0;
      end
   end

   // Remap is sticky until the next reset.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
         remapped_out <= 1'b0;
      else if (remap_cmd_in)
         remapped_out <= 1'b1;
   end

endmodule // sadr_nvbits

// *** src/sadr_prefetch.v ***
// Dual 32-bit flash prefetch buffer.
`timescale 1ns/100ps
module sadr_prefetch
#(
   parameter AW = 17
)
(
   // Clock and reset.
   input  wire          core_clk_in,
   input  wire          reset_in,
   // Lookup word address.
   input  wire [AW-1:0] look_word_in,
   // Fill from the flash array, one aligned pair of words.
   input  wire          fill_valid_in,
   input  wire [AW-1:0] fill_word_in,
   input  wire [63:0]   fill_data_in,
   // Invalidate after programming.
   input  wire          flush_in,
   // Lookup answer.
   output wire          hit_out,
   output wire [31:0]   data_out
);

   reg          valid_reg;   // Pair holds good data.
   reg [AW-2:0] tag_reg;     // Pair address, word bit 0 dropped.
   reg [63:0]   pair_reg;    // Low word then high word.

   // A pair serves up to four consecutive halfword fetches.
   assign hit_out  = valid_reg && tag_reg == look_word_in[AW-1:1];
   assign data_out = look_word_in[0] ? pair_reg[63:32] : pair_reg[31:0];

   // Pair load and flush; flush wins so stale data is never served.
   always @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         valid_reg <= 1'b0;
         tag_reg   <= {(AW-1){1'b0}};
         pair_reg  <= 64'h0;
      end
      else if (flush_in)
         valid_reg <= 1'b0;
      else if (fill_valid_in)
      begin
         valid_reg <= 1'b1;
         tag_reg   <= fill_word_in[AW-1:1];
         pair_reg  <= fill_data_in;
      end
   end

endmodule // sadr_prefetch

// *** verification/sadr_decoder_chk.sv ***
// Port-level checker for the system address decoder.
`timescale 1ns/100ps
module sadr_decoder_chk
#(
   parameter SRAM_BYTES  = 32768,
   parameter FLASH_WORDS = 131072
)
(
   // Clock and reset.
   input logic        core_clk_in,
   input logic        reset_in,
   // Requests and state commands.
   input logic        req_valid_in,
   input logic [31:0] req_addr_in,
   input logic        req_write_in,
   input logic        remap_cmd_in,
   input logic        nv_set_in,
   input logic [1:0]  nv_bit_in,
   input logic        erase_pin_in,
   input logic [1:0]  plane_busy_in,
   // Decoder answers.
   input logic        sram_sel_out,
   input logic        rom_sel_out,
   input logic        flash_sel_out,
   input logic        periph_sel_out,
   input logic [7:0]  external_select_n_out,
   input logic        abort_out,
   input logic        stall_out,
   input logic [19:0] mem_offset_out,
   input logic        boot_flash_out,
   input logic        remapped_out
);
   // Area and region fields of the request address.
   wire [3:0]  area = req_addr_in[31:28];
   wire [11:0] top  = req_addr_in[31:20];
   wire        rd   = req_valid_in && !req_write_in;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // Erase pin held long enough to pass the two-stage synchroniser.
   sequence s_erase_held;
      erase_pin_in [*4];
   endsequence
   // Boot bit set with no erase in flight that could override it.
   sequence s_boot_set;
      nv_set_in && nv_bit_in == 2'h2 && !$past(reset_in) && !erase_pin_in
      && !$past(erase_pin_in) && !$past(erase_pin_in, 2);
   endsequence
   a_ext_select: assert property (req_valid_in && area >= 4'h1 && area <= 4'h8
      |=> external_select_n_out == ~(8'h01 << ($past(area) - 4'h1)))
      else $error("external select does not match area");
   a_abort_area: assert property (req_valid_in && area >= 4'h9 && area <= 4'he
      |=> abort_out && external_select_n_out == 8'hff && !periph_sel_out)
      else $error("unused area not aborted");
   a_periph_area: assert property (req_valid_in && area == 4'hf
      |=> periph_sel_out && !abort_out) else $error("peripheral area missed");
   a_rom_fixed: assert property (req_valid_in && top == 12'h003
      |=> rom_sel_out && mem_offset_out == $past(req_addr_in[19:0]))
      else $error("rom not selected at its base");
   a_flash_fixed: assert property (rd && top == 12'h001
      && req_addr_in[19:0] < FLASH_WORDS * 4 && plane_busy_in == 2'h0
      |=> flash_sel_out && !stall_out) else $error("flash read missed");
   a_busy_stall: assert property (rd && top == 12'h001 && plane_busy_in[0]
      && req_addr_in[19:18] == 2'h0 |=> stall_out && !flash_sel_out)
      else $error("busy plane read not stalled");
   a_sram_window: assert property (req_valid_in && top == 12'h002
      |=> sram_sel_out == ($past(req_addr_in[19:0]) < SRAM_BYTES))
      else $error("sram window size wrong");
   a_region_abort: assert property (req_valid_in && area == 4'h0
      && req_addr_in[27:20] >= 8'h04 |=> abort_out)
      else $error("unused internal region not aborted");
   a_remap_sram: assert property (remapped_out && req_valid_in
      && top == 12'h000 && req_addr_in[19:0] < SRAM_BYTES
      |=> sram_sel_out && !rom_sel_out) else $error("zero not sram after remap");
   a_remap_level: assert property (remap_cmd_in |-> ##2 remapped_out [*3])
      else $error("remap state not held");
   a_erase_clear: assert property (s_erase_held |=> !boot_flash_out)
      else $error("erase left boot bit set");
   a_boot_set: assert property (s_boot_set |-> ##2 boot_flash_out)
      else $error("boot bit set command ignored");
endmodule // sadr_decoder_chk

bind sadr_decoder sadr_decoder_chk #(.SRAM_BYTES(SRAM_BYTES),
   .FLASH_WORDS(FLASH_WORDS)) chk (.core_clk_in, .reset_in, .req_valid_in,
   .req_addr_in, .req_write_in, .remap_cmd_in, .nv_set_in, .nv_bit_in,
   .erase_pin_in, .plane_busy_in, .sram_sel_out, .rom_sel_out,
   .flash_sel_out, .periph_sel_out, .external_select_n_out, .abort_out,
   .stall_out, .mem_offset_out, .boot_flash_out, .remapped_out);

// *** verification/sadr_bus_master.sv ***
// Bus master stand-in that issues one decoder request per call.
`timescale 1ns/100ps
module sadr_bus_master
(
   // Clock.
   input  logic        core_clk_in,
   // Request toward the decoder.
   output logic        req_valid_out,
   output logic [31:0] req_addr_out,
   output logic        req_write_out
);
   initial
   begin
      req_valid_out = 1'b0;
      req_addr_out  = 32'h0000_0000;
      req_write_out = 1'b0;
   end
   // Called one step after an edge; an idle edge passes first so the lines
   // are never driven twice in the step that released them, and the
   // request then stands until the taking edge.
   task automatic issue(input logic [31:0] addr, input logic wr);
      @(posedge core_clk_in);
      #1;
      req_valid_out = 1'b1;
      req_addr_out  = addr;
      req_write_out = wr;
      @(posedge core_clk_in);
      #1;
      // Released lines show inverted values so stale ones never pass.
      req_valid_out = 1'b0;
      req_addr_out  = ~addr;
      req_write_out = ~wr;
   endtask
endmodule // sadr_bus_master

// *** verification/tb_top.sv ***
// Self-checking bench for the system address decoder.
`timescale 1ns/100ps
`include "sadr_map.vh"
module tb_top;
   // Stimulus driven by the bench.
   logic        core_clk_in, reset_in, remap_cmd_in, nv_set_in, nv_clear_in;
   logic        nv_boot_stored_in, erase_pin_in, fill_valid_in;
   logic [1:0]  nv_bit_in, plane_busy_in;
   logic [63:0] fill_data_in;
   // Request lines from the master model.
   wire         req_valid_in, req_write_in;
   wire  [31:0] req_addr_in;
   // Decoder answers.
   wire         sram_sel_out, rom_sel_out, flash_sel_out, wbuf_sel_out;
   wire         periph_sel_out, abort_out, stall_out, flash_plane_out;
   wire         prefetch_hit_out, flash_fetch_out, boot_flash_out;
   wire         remapped_out;
   wire  [7:0]  external_select_n_out;
   wire  [19:0] mem_offset_out;
   wire  [16:0] flash_word_out;
   wire  [5:0]  wbuf_index_out;
   wire  [31:0] prefetch_data_out;
   int          err_count, n_compared;
   localparam logic [31:0] FB = `SADR_FLASH_BASE;
   localparam logic [31:0] SB = `SADR_SRAM_BASE;

   sadr_bus_master m (.core_clk_in, .req_valid_out(req_valid_in),
      .req_addr_out(req_addr_in), .req_write_out(req_write_in));
   sadr_decoder uut (.core_clk_in, .reset_in, .req_valid_in, .req_addr_in,
      .req_write_in, .remap_cmd_in, .nv_set_in, .nv_clear_in, .nv_bit_in,
      .nv_boot_stored_in, .erase_pin_in, .plane_busy_in, .fill_valid_in,
      .fill_data_in, .sram_sel_out, .rom_sel_out, .flash_sel_out,
      .wbuf_sel_out, .periph_sel_out, .external_select_n_out, .abort_out,
      .stall_out, .mem_offset_out, .flash_word_out, .flash_plane_out,
      .wbuf_index_out, .prefetch_hit_out, .prefetch_data_out,
      .flash_fetch_out, .boot_flash_out, .remapped_out);

   // Compare one observed value with its expectation.
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Miss, fill, then a hit served from the buffered pair.
   task automatic t_prefetch;
      m.issue(FB + 32'h8, 1'b0);
      chk(flash_fetch_out, 1'b1);
      fill_data_in  = 64'h2222_2222_1111_1111;
      fill_valid_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      fill_valid_in = 1'b0;
      m.issue(FB + 32'hc, 1'b0);
      chk({prefetch_hit_out, flash_fetch_out}, 2'b10);
      chk(prefetch_data_out, 32'h2222_2222);
   endtask

   // Every first level area once.
   task automatic t_areas;
      logic [7:0] e;
      for (int a = 0; a < 16; a++)
      begin
         e = (a >= 1 && a <= 8) ? ~(8'h01 << (a - 1)) : 8'hff;
         m.issue({a[3:0], 28'h000_0010}, 1'b0);
         chk(external_select_n_out, e);
         chk({periph_sel_out, abort_out}, {a == 15, a >= 9 && a <= 14});
         chk(rom_sel_out, a == 0);
      end
   endtask

   // Internal regions at their edges; vector is sram,rom,flash,wbuf,abort.
   task automatic t_internal;
      logic [31:0] ad [8];
      logic [4:0]  ex [8];
      ad = '{SB + 32'h4, SB + `SADR_SRAM_BYTES - 4, SB + `SADR_SRAM_BYTES,
         `SADR_ROM_BASE + 32'h8, FB + 4 * `SADR_FLASH_WORDS - 4,
         FB + 4 * `SADR_FLASH_WORDS, FB + 32'h10, 32'h0040_0000};
      ex = '{5'h10, 5'h10, 5'h01, 5'h08, 5'h04, 5'h01, 5'h02, 5'h01};
      for (int i = 0; i < 8; i++)
      begin
         m.issue(ad[i], i == 6);
         chk({sram_sel_out, rom_sel_out, flash_sel_out, wbuf_sel_out,
            abort_out}, ex[i]);
         if (!ex[i][0])
            chk(mem_offset_out, ad[i][19:0]);
         if (ex[i][2])
            chk({flash_plane_out, flash_word_out},
               {ad[i][18], ad[i][18:2]});
         if (ex[i][1])
            chk(wbuf_index_out, ad[i][7:2]);
      end
   endtask

   // Plane 0 programming: its reads stall, plane 1 and writes go on.
   task automatic t_stall;
      plane_busy_in = 2'b01;
      m.issue(FB, 1'b0);
      chk({stall_out, flash_sel_out}, 2'b10);
      m.issue(FB + 32'h4_0000, 1'b0);
      chk({stall_out, flash_sel_out}, 2'b01);
      m.issue(FB, 1'b1);
      chk({stall_out, wbuf_sel_out, abort_out}, 3'b010);
      plane_busy_in = 2'b00;
   endtask

   // Non-volatile bit command, then wait for the registered copy.
   task automatic nv_cmd(input logic set, input logic [1:0] b);
      nv_set_in   = set;
      nv_clear_in = !set;
      nv_bit_in   = b;
      @(posedge core_clk_in);
      #1;
      nv_set_in   = 1'b0;
      nv_clear_in = 1'b0;
      @(posedge core_clk_in);
      #1;
   endtask

   // Boot bit steering of address zero, and erase.
   task automatic t_boot;
      nv_cmd(1'b1, 2'h1);
      m.issue(32'h0, 1'b0);
      chk({boot_flash_out, sram_sel_out, rom_sel_out}, 3'b001);
      nv_cmd(1'b1, 2'h2);
      m.issue(32'h4, 1'b0);
      chk({boot_flash_out, flash_sel_out}, 2'b11);
      nv_cmd(1'b0, 2'h2);
      m.issue(32'h0, 1'b0);
      chk({boot_flash_out, rom_sel_out}, 2'b01);
      nv_cmd(1'b1, 2'h2);
      erase_pin_in = 1'b1;
      repeat (4) @(posedge core_clk_in);
      #1;
      erase_pin_in = 1'b0;
      @(posedge core_clk_in);
      #1;
      chk(boot_flash_out, 1'b0);
   endtask

   // Remap puts SRAM at zero and keeps the fixed bases.
   task automatic t_remap;
      remap_cmd_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      remap_cmd_in = 1'b0;
      m.issue(32'h8, 1'b0);
      chk({sram_sel_out, rom_sel_out, mem_offset_out}, {2'b10, 20'h8});
      m.issue(SB, 1'b0);
      chk({remapped_out, sram_sel_out}, 2'b11);
      m.issue(`SADR_ROM_BASE, 1'b0);
      chk(rom_sel_out, 1'b1);
      m.issue(FB, 1'b0);
      chk(flash_sel_out, 1'b1);
   endtask

   initial
   begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end

   // Hang guard, far beyond the 93 or so cycles the run needs.
   initial
   begin
      #8000;
      err_count++;
      final_report();
   end

   initial
   begin
      {reset_in, remap_cmd_in, nv_set_in, nv_clear_in} = 4'h8;
      {nv_boot_stored_in, erase_pin_in, fill_valid_in} = 3'h0;
      nv_bit_in     = 2'h0;
      plane_busy_in = 2'h0;
      fill_data_in  = 64'h0;
      repeat (5) @(posedge core_clk_in);
      #1;
      reset_in = 1'b0;
      @(posedge core_clk_in);
      #1;
      t_prefetch();
      t_areas();
      t_internal();
      t_stall();
      t_boot();
      t_remap();
      final_report();
   end
endmodule // tb_top
